//--- bench/lvd_ana_model.sv
// comparator and external trip input model
`timescale 1ns/100ps
`default_nettype none
module lvd_ana_model (
   input  wire lvd_pkg::lvd_ana_ctrl_t ana_ctrl_i,
   input  wire logic [3:0]             supply_i,
   input  wire logic                   ext_below_i,
   output logic                        below_o
);
   // unpowered comparator modelled as quiet; reserved code still compares
   assign below_o = ana_ctrl_i.power_on && (ana_ctrl_i.tap_sel_ext ? ext_below_i
      : supply_i <= ana_ctrl_i.tap_code);
endmodule
`default_nettype wire

//--- bench/lvd_ctrl_asserts.sv
// port assertions for the detector control block
`timescale 1ns/100ps
`default_nettype none
module lvd_ctrl_asserts
   import lvd_pkg::*;
#(parameter int SETTLE_CYCLES = 8) (
   input wire logic                   mclk_i,
   input wire logic                   rstn_i,
   input wire logic [3:0]             avs_address_i,
   input wire logic                   avs_read_i,
   input wire logic                   avs_write_i,
   input wire logic [31:0]            avs_readdata_o,
   input wire logic                   avs_waitrequest_o,
   input wire logic                   brownout_reset_en_i,
   input wire logic                   global_irq_enable_i,
   input wire lvd_pkg::lvd_ana_ctrl_t ana_ctrl_o,
   input wire logic                   ref_power_o,
   input wire logic                   wake_o,
   input wire logic                   vector_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   sequence bus_req_s;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence ctrl_read_s;
      avs_read_i && !avs_waitrequest_o && avs_address_i == LVD_ADDR_CTRL;
   endsequence
   bus_answer_a: assert property (bus_req_s |=> !avs_waitrequest_o)
      else $error("request not answered");
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   ctrl_top_zero_a: assert property (ctrl_read_s |-> avs_readdata_o[31:6] == '0)
      else $error("control top bits set");
   ref_keep_a: assert property (brownout_reset_en_i |=> ref_power_o)
      else $error("reference off under brownout");
   ref_detector_a: assert property (
      ana_ctrl_o.power_on && $past(ana_ctrl_o.power_on) |-> ref_power_o)
      else $error("reference off under detector");
   ext_route_a: assert property (ana_ctrl_o.power_on |->
      ana_ctrl_o.tap_sel_ext == (ana_ctrl_o.tap_code == LVD_LEVEL_EXT))
      else $error("wrong input routing");
   settle_quiet_a: assert property ($rose(ana_ctrl_o.power_on) && $rose(ref_power_o) |=>
      !wake_o [*8])
      else $error("trip before reference settled");
   wake_gate_a: assert property (wake_o |-> ana_ctrl_o.power_on)
      else $error("wake while detector off");
   vector_gate_a: assert property (vector_o |-> wake_o && $past(global_irq_enable_i))
      else $error("vector without wake or enable");
   reset_off_a: assert property (disable iff (1'b0) !rstn_i |=>
      avs_waitrequest_o && !ana_ctrl_o.power_on && !ref_power_o)
      else $error("outputs not reset");
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the detector control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import lvd_pkg::*;
   logic          mclk_i, rstn_i, rd, wr, brown, sleep, global_irq_enable, ext, below;
   logic          wait_r, wake, vec, lvd_irq, irq, ref_pw;
   logic [3:0]    addr, supply;
   logic [31:0]   wdata, rdata, bus_q;
   lvd_ana_ctrl_t ana;
   int            miscompares, check_count;
   logic [23:0]   rows [11] = '{24'h000005, 24'h03001F, 24'h020000, 24'h060000,
      24'h10C300, 24'h000003, 24'h165500, 24'h060000, 24'h150700, 24'h050007, 24'h150000};
   lvd_ctrl #(.SETTLE_CYCLES(8)) u_lvd_ctrl (.mclk_i, .rstn_i, .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .comp_below_i(below),
      .brownout_reset_en_i(brown), .sleep_i(sleep), .global_irq_enable_i(global_irq_enable),
      .ana_ctrl_o(ana), .ref_power_o(ref_pw), .wake_o(wake), .vector_o(vec),
      .lvd_irq_o(lvd_irq), .irq_o(irq));
   lvd_ana_model u_lvd_ana_model (.ana_ctrl_i(ana), .supply_i(supply), .ext_below_i(ext),
      .below_o(below));
   task automatic complete_run();
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      // values read straight after the edge are the ones the edge sampled
      do begin
         @(posedge mclk_i);
         n++;
      end while (wait_r !== 1'b0 && n < 50);
      // read data is taken at the very edge that sees waitrequest low
      bus_q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         complete_run();
      end
      @(posedge mclk_i);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(bus_q, {24'h0, e});
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wake_chk(input logic g);
      int n;
      n = 0;
      bus(1'b1, LVD_ADDR_FLAGS, 8'h00);
      global_irq_enable <= g;
      sleep <= 1'b1;
      supply <= 4'h0;
      while (wake !== 1'b1 && n < 20) begin
         @(posedge mclk_i);
         n++;
      end
      chk({31'h0, wake}, 32'h1);
      chk({31'h0, vec}, {31'h0, g});
      supply <= 4'hF;
      sleep <= 1'b0;
      wait_clk(6);
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      #20000;
      miscompares++;
      complete_run();
   end
   initial begin
      {rstn_i, rd, wr, brown, sleep, global_irq_enable, ext, addr, wdata} = '0;
      supply = 4'hF;
      miscompares = 0;
      check_count = 0;
      wait_clk(4);
      rstn_i <= 1'b1;
      wait_clk(1);
      foreach (rows[i]) begin
         bus(rows[i][20], rows[i][19:16], rows[i][15:8]);
         if (!rows[i][20]) chk(bus_q, {24'h0, rows[i][7:0]});
      end
      supply <= 4'h0;
      bus(1'b1, LVD_ADDR_CTRL, 8'h0A);
      bus(1'b1, LVD_ADDR_CTRL, 8'h1A);
      rdc(LVD_ADDR_CTRL, 8'h1A);
      rdc(LVD_ADDR_FLAGS, 8'h00);
      wait_clk(10);
      rdc(LVD_ADDR_CTRL, 8'h3A);
      rdc(LVD_ADDR_FLAGS, 8'h04);
      supply <= 4'hF;
      wait_clk(5);
      bus(1'b1, LVD_ADDR_FLAGS, 8'h00);
      rdc(LVD_ADDR_STATUS, 8'h03);
      bus(1'b1, LVD_ADDR_MASK, 8'h01);
      wait_clk(2);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, LVD_ADDR_STATUS, 8'h03);
      wait_clk(2);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, LVD_ADDR_ENAB, 8'h04);
      supply <= 4'h0;
      wait_clk(3);
      supply <= 4'hF;
      wait_clk(6);
      chk({31'h0, lvd_irq}, 32'h1);
      rdc(LVD_ADDR_FLAGS, 8'h04);
      bus(1'b1, LVD_ADDR_FLAGS, 8'h00);
      wait_clk(2);
      chk({31'h0, lvd_irq}, 32'h0);
      wake_chk(1'b1);
      wake_chk(1'b0);
      bus(1'b1, LVD_ADDR_CTRL, 8'h10);
      bus(1'b1, LVD_ADDR_FLAGS, 8'h00);
      supply <= 4'h0;
      wait_clk(12);
      rdc(LVD_ADDR_FLAGS, 8'h00);
      // supply back up first, so the old tap cannot trip once the code leaves 0000
      supply <= 4'hF;
      bus(1'b1, LVD_ADDR_CTRL, 8'h1F);
      wait_clk(6);
      rdc(LVD_ADDR_FLAGS, 8'h00);
      ext <= 1'b1;
      wait_clk(6);
      rdc(LVD_ADDR_FLAGS, 8'h04);
      bus(1'b1, LVD_ADDR_CTRL, 8'h05);
      brown <= 1'b1;
      wait_clk(2);
      chk({31'h0, ref_pw}, 32'h1);
      rdc(LVD_ADDR_CTRL, 8'h05);
      bus(1'b1, LVD_ADDR_CTRL, 8'h1A);
      rstn_i <= 1'b0;
      brown <= 1'b0;
      wait_clk(2);
      rstn_i <= 1'b1;
      wait_clk(2);
      chk({31'h0, ref_pw}, 32'h0);
      rdc(LVD_ADDR_CTRL, 8'h05);
      complete_run();
   end
endmodule
bind lvd_ctrl lvd_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_lvd_ctrl_asserts (.mclk_i,
   .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
   .brownout_reset_en_i, .global_irq_enable_i, .ana_ctrl_o, .ref_power_o, .wake_o, .vector_o);
`default_nettype wire

//--- hw/lvd_ctrl.sv
// low voltage detector control: registers, reference settling, flag, wake and interrupt
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module lvd_ctrl #(
   parameter int SETTLE_CYCLES = lvd_pkg::LVD_SETTLE_CYCLES
) (
   input  wire logic                  mclk_i,
   input  wire logic                  rstn_i,
   input  wire logic [3:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   input  wire logic [3:0]            avs_byteenable_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   input  wire logic                  comp_below_i,
   input  wire logic                  brownout_reset_en_i,
   input  wire logic                  sleep_i,
   input  wire logic                  global_irq_enable_i,
   output lvd_pkg::lvd_ana_ctrl_t     ana_ctrl_o,
   output logic                       ref_power_o,
   output logic                       wake_o,
   output logic                       vector_o,
   output logic                       lvd_irq_o,
   output logic                       irq_o
);
   import lvd_pkg::*;

   logic [3:0]            trip_level_select_r;
   logic                  detector_power_enable_r;
   logic                  ref_stable_flag_r;
   logic [7:0]            flags_r;
   logic [7:0]            enables_r;
   logic [7:0]            prio_r;
   logic [LVD_EV_W-1:0]   status_r;
   logic [LVD_EV_W-1:0]   mask_r;
   lvd_state_t            state_r;
   logic [31:0]           settle_cnt_r;
   logic                  comp_s1_r;
   logic                  comp_s2_r;
   logic                  access_r;
   logic                  wr_hit;
   logic                  rd_hit;
   logic                  trip;
   logic                  ref_need;
   logic                  stable_rise;
   logic [LVD_EV_W-1:0]   ev;
   logic [7:0]            ctrl_rd;
   logic [31:0]           rd_nxt;

   // one wait state: each access completes on its second cycle
   assign wr_hit = avs_write_i && access_r && avs_byteenable_i[0];
   assign rd_hit = avs_read_i && access_r;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         access_r <= 1'b0;
      end else begin
         access_r <= (avs_read_i || avs_write_i) && !access_r;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !access_r);
      end
   end

   // comparator output is asynchronous to mclk
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         comp_s1_r <= 1'b0;
         comp_s2_r <= 1'b0;
      end else begin
         comp_s1_r <= comp_below_i;
         comp_s2_r <= comp_s1_r;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin // see (RULE13) (RULE16)
         trip_level_select_r     <= LVD_CTRL_RST[3:0];
         detector_power_enable_r <= LVD_CTRL_RST[LVD_CTRL_EN_BIT];
      end else if (wr_hit && avs_address_i == LVD_ADDR_CTRL) begin
         trip_level_select_r     <= avs_writedata_i[3:0]; // see (RULE2)
         detector_power_enable_r <= avs_writedata_i[LVD_CTRL_EN_BIT]; // see (RULE6)
      end
   end

   assign ref_need = detector_power_enable_r || brownout_reset_en_i; // see (RULE10)

   // settling counted in mclk cycles derived from an absolute time
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         state_r      <= LVD_OFF;
         settle_cnt_r <= '0;
      end else begin
         case (state_r)
            LVD_OFF: begin
               settle_cnt_r <= '0;
               if (ref_need) begin
                  state_r <= LVD_SETTLE;
               end
            end
            LVD_SETTLE: begin
               settle_cnt_r <= settle_cnt_r + 32'h1;
               if (!ref_need) begin
                  state_r <= LVD_OFF;
               end else if (settle_cnt_r >= 32'(SETTLE_CYCLES - 1)) begin // see (RULE9)
                  state_r <= LVD_READY;
               end
            end
            LVD_READY: begin
               if (!ref_need) begin
                  state_r <= LVD_OFF;
               end
            end
            default: begin
               state_r <= LVD_OFF;
            end
         endcase
      end
   end

   // stable flag only meaningful while the detector itself is on
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ref_stable_flag_r <= 1'b0;
      end else begin
         ref_stable_flag_r <= (state_r == LVD_READY) && detector_power_enable_r; // see (RULE5)
      end
   end

   // reserved code 0000 never trips: trip is gated off while it is selected
   assign trip = comp_s2_r && ref_stable_flag_r && detector_power_enable_r
                 && (trip_level_select_r != LVD_LEVEL_RSVD); // see (RULE1) (RULE8) (RULE4)

   assign stable_rise = (state_r == LVD_READY) && detector_power_enable_r && !ref_stable_flag_r;

   // hardware set wins over software clear
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         flags_r <= LVD_FLAGS_RST;
      end else begin
         if (wr_hit && avs_address_i == LVD_ADDR_FLAGS) begin
            flags_r <= avs_writedata_i[7:0] & LVD_PERIPH_MSK;
         end
         if (trip) begin
            flags_r[LVD_FLAG_BIT] <= 1'b1; // see (RULE15)
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         enables_r <= LVD_ENAB_RST;
         prio_r    <= LVD_PRIO_RST;
      end else if (wr_hit && avs_address_i == LVD_ADDR_ENAB) begin
         enables_r <= avs_writedata_i[7:0] & LVD_PERIPH_MSK;
      end else if (wr_hit && avs_address_i == LVD_ADDR_PRIO) begin
         prio_r <= avs_writedata_i[7:0] & LVD_PERIPH_MSK;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         lvd_irq_o <= 1'b0;
      end else begin
         lvd_irq_o <= flags_r[LVD_FLAG_BIT] && enables_r[LVD_FLAG_BIT]; // see (RULE15)
      end
   end

   // wake on a trip in sleep; vector only with global enable
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wake_o   <= 1'b0;
         vector_o <= 1'b0;
      end else begin
         wake_o   <= sleep_i && trip; // see (RULE11)
         vector_o <= sleep_i && trip && global_irq_enable_i
                     && enables_r[LVD_FLAG_BIT]; // see (RULE12)
      end
   end

   assign ev[LVD_EV_TRIP]   = trip && !flags_r[LVD_FLAG_BIT];
   assign ev[LVD_EV_STABLE] = stable_rise;
   assign ev[LVD_EV_WAKE]   = sleep_i && trip;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         status_r <= '0;
         mask_r   <= '0;
      end else begin
         if (wr_hit && avs_address_i == LVD_ADDR_STATUS) begin
            status_r <= (status_r & ~avs_writedata_i[LVD_EV_W-1:0]) | ev;
         end else begin
            status_r <= status_r | ev;
         end
         if (wr_hit && avs_address_i == LVD_ADDR_MASK) begin
            mask_r <= avs_writedata_i[LVD_EV_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_r & mask_r);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ana_ctrl_o  <= '0;
         ref_power_o <= 1'b0;
      end else begin
         ana_ctrl_o.power_on    <= detector_power_enable_r; // see (RULE6)
         ana_ctrl_o.tap_code    <= trip_level_select_r;
         ana_ctrl_o.tap_sel_ext <= (trip_level_select_r == LVD_LEVEL_EXT); // see (RULE3)
         ref_power_o            <= ref_need; // see (RULE10)
      end
   end

   assign ctrl_rd = {2'b00, ref_stable_flag_r, detector_power_enable_r,
                     trip_level_select_r}; // see (RULE7)

   always_comb begin
      rd_nxt = '0;
      case (avs_address_i)
         LVD_ADDR_CTRL:   rd_nxt[7:0] = ctrl_rd;
         LVD_ADDR_FLAGS:  rd_nxt[7:0] = flags_r;
         LVD_ADDR_ENAB:   rd_nxt[7:0] = enables_r;
         LVD_ADDR_PRIO:   rd_nxt[7:0] = prio_r;
         LVD_ADDR_STATUS: rd_nxt[LVD_EV_W-1:0] = status_r;
         LVD_ADDR_MASK:   rd_nxt[LVD_EV_W-1:0] = mask_r;
         default:         rd_nxt = '0;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= '0;
      end else if (avs_read_i && !access_r) begin
         avs_readdata_o <= rd_nxt;
      end
   end
endmodule
`default_nettype wire

//--- hw/lvd_pkg.sv
// package: register map, field layout, reset values and timing for the low voltage detector
// Overview of operation
// (RULE1) flag sets when the selected tap falls below the reference.
// (RULE2) trip level is a 4-bit field in control bits 3:0, 16 settings.
// (RULE3) code 1111 routes the comparator to the external trip input.
// (RULE4) codes 0001..1110 pick rising divider taps; 0000 is reserved.
// (RULE5) control bit 5 is read-only reference-stable flag, resets to 0.
// (RULE6) control bit 4 powers and enables the detector when 1.
// (RULE7) control bits 7 and 6 always read zero.
// (RULE8) flag setting is suppressed until the reference is stable.
// (RULE9) reference settling delay is an absolute time, not clock based.
// (RULE10) reference runs while detector or brown-out reset needs it.
// (RULE11) detector works in sleep; a trip sets the flag and wakes the core.
// (RULE12) after wake, vector only if global interrupts are enabled.
// (RULE13) any reset returns control to reset state, detector off.
// (RULE14) software: set level, irq off, enable, wait stable, clear flag, irq on.
// (RULE15) flag is sticky until cleared; irq when flag and enable both set.
// (RULE16) control register resets to 0x05.
package lvd_pkg;
   localparam logic [3:0] LVD_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] LVD_ADDR_FLAGS  = 4'h1;
   localparam logic [3:0] LVD_ADDR_ENAB   = 4'h2;
   localparam logic [3:0] LVD_ADDR_PRIO   = 4'h3;
   localparam logic [3:0] LVD_ADDR_STATUS = 4'h4;
   localparam logic [3:0] LVD_ADDR_MASK   = 4'h5;

   localparam int         LVD_CTRL_STABLE_BIT = 5;
   localparam int         LVD_CTRL_EN_BIT     = 4;
   localparam int         LVD_FLAG_BIT        = 2;
   localparam logic [7:0] LVD_CTRL_RST   = 8'h05;
   localparam logic [7:0] LVD_FLAGS_RST  = 8'h00;
   localparam logic [7:0] LVD_ENAB_RST   = 8'h00;
   localparam logic [7:0] LVD_PRIO_RST   = 8'h1F;
   localparam logic [7:0] LVD_PERIPH_MSK = 8'h1E;
   localparam logic [3:0] LVD_LEVEL_EXT  = 4'hF;
   localparam logic [3:0] LVD_LEVEL_RSVD = 4'h0;

   // status/mask event bits
   localparam int LVD_EV_TRIP   = 0;
   localparam int LVD_EV_STABLE = 1;
   localparam int LVD_EV_WAKE   = 2;
   localparam int LVD_EV_W      = 3;

   localparam int LVD_CLK_MHZ        = 250;
   localparam int LVD_SETTLE_US      = 20;
   localparam int LVD_SETTLE_CYCLES  = LVD_SETTLE_US * LVD_CLK_MHZ;

   typedef enum logic [1:0] {
      LVD_OFF    = 2'b00,
      LVD_SETTLE = 2'b01,
      LVD_READY  = 2'b11
   } lvd_state_t;

   typedef struct packed {
      logic       tap_sel_ext;
      logic [3:0] tap_code;
      logic       power_on;
   } lvd_ana_ctrl_t;
endpackage
